/* File: pkg/imwc_pkg.sv */
// Package for the idle mode and wake controller: register map, fields, timing constants
package imwc_pkg;
  // Register byte offsets
  localparam logic [7:0] IMWC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] IMWC_STATUS_OFS = 8'h04;
  localparam logic [7:0] IMWC_CMD_OFS    = 8'h08;
  // Control register fields
  localparam int IMWC_CTL_IDLE_BIT   = 0;
  localparam int IMWC_CTL_SCS_LSB    = 1;
  localparam int IMWC_CTL_T1EN_BIT   = 3;
  localparam int IMWC_CTL_FSEL_LSB   = 4;
  localparam int IMWC_CTL_LFSRC_BIT  = 7;
  localparam int IMWC_CTL_GIRQ_BIT   = 8;
  localparam int IMWC_CTL_WDTEN_BIT  = 9;
  localparam int IMWC_CTL_FSCM_BIT   = 10;
  localparam int IMWC_CTL_TWOSP_BIT  = 11;
  localparam logic [11:0] IMWC_CTRL_RST = 12'h000;
  // Command register bits (write one to act)
  localparam int IMWC_CMD_SLEEP_BIT  = 0;
  localparam int IMWC_CMD_WDCLR_BIT  = 1;
  // Status register fields
  localparam int IMWC_ST_PRI_BIT     = 0;
  localparam int IMWC_ST_SEC_BIT     = 1;
  localparam int IMWC_ST_ISTB_BIT    = 2;
  localparam int IMWC_ST_CPU_BIT     = 3;
  localparam int IMWC_ST_MODE_LSB    = 4;
  localparam int IMWC_ST_IOSC_BIT    = 8;
  localparam int IMWC_ST_LFOSC_BIT   = 9;
  localparam int IMWC_ST_PRION_BIT   = 10;
  // Timing
  localparam int IMWC_CLK_HZ         = 20000000;
  localparam int IMWC_TCSD_NS        = 1000;
  localparam int IMWC_TIOBST_NS      = 1000000;
  localparam int IMWC_TOST_CYC       = 1024;
  localparam int IMWC_TCSD_CYC   = (IMWC_TCSD_NS * (IMWC_CLK_HZ / 1000000) + 999) / 1000;
  localparam int IMWC_TIOBST_CYC = (IMWC_TIOBST_NS / 1000) * (IMWC_CLK_HZ / 1000000);
  localparam int IMWC_CNT_W          = 16;
  localparam int IMWC_WDT_W          = 16;
  // Power modes
  typedef enum logic [2:0] {
    IMWC_RUN      = 3'b000,
    IMWC_PRIMARY_IDLE_MODE = 3'b001,
    IMWC_SECONDARY_IDLE_MODE = 3'b010,
    IMWC_INT_IDLE = 3'b011,
    IMWC_SLEEP    = 3'b100,
    IMWC_WAKE     = 3'b101,
    IMWC_RSTHOLD  = 3'b110
  } imwc_mode_t;
endpackage

/* File: logic/imwc_delay.sv */
// Down counter that reports done once a started delay has elapsed
module imwc_delay
  import imwc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  start,
  input  wire logic                  clear,
  input  wire logic [IMWC_CNT_W-1:0] len,
  output logic                       done
);
  logic [IMWC_CNT_W-1:0] cnt_r;
  logic                  run_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= len;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = run_r && (cnt_r == '0) && !start;
endmodule

/* File: logic/imwc_wdt.sv */
// Watchdog counter with clear, reporting a one-cycle time-out pulse
module imwc_wdt
  import imwc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  enable,
  input  wire logic                  clear,
  input  wire logic [IMWC_WDT_W-1:0] period,
  output logic                       timeout
);
  logic [IMWC_WDT_W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !enable) begin
      cnt_r <= '0;
    end else if (cnt_r >= period) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign timeout = enable && !clear && (cnt_r >= period);
endmodule

/* File: logic/imwc_top.sv */
// Idle mode and wake controller with AXI4-Lite register access
// Operation
// - Primary idle: CPU clock off, peripherals on primary, primary ready stays set
// - Primary idle wake: CPU on primary after start delay, ready flag kept
// - Sleep with idle and select 01: primary off, ready clear, secondary active set
// - Secondary idle sleep ignored when secondary oscillator enable is clear
// - Secondary idle wake: CPU resumes on secondary after start delay
// - Upper select bit chooses internal idle, lower bit ignored, primary shut off
// - Internal output on when frequency or source select set; stable after settle
// - Already stable internal output keeps stable flag with no new settle
// - All selects zero: internal output disabled, stable flag clear
// - Internal idle wake: CPU resumes on internal multiplexer after start delay
// - Low-frequency oscillator runs while watchdog or fail monitor enabled
// - Wake leaves idle enable and clock select unchanged
// - Leave sleep or idle only on interrupt, reset or watchdog time-out
// - Only enabled interrupt sources wake; wake starts when flag sets
// - Interrupt wake branches to vector only when global enable set
// - Interrupt and watchdog exits insert the start delay; resume on primary also waits for primary ready unless dual-speed or fail monitor set
// - Watchdog time-out wakes from idle or sleep, resets in run modes
// - Watchdog cleared by sleep, clear, clock loss, frequency writes on internal
// - Reset exit held by start-up timer until primary ready, then flag set
// - Dual-speed or fail monitor: run without waiting for primary ready, clock select unchanged
// - Sleep with idle enable clear stops primary oscillator, clears primary and secondary flags
module imwc_top
  import imwc_pkg::*;
#(
  parameter int TIOBST_CYC = IMWC_TIOBST_CYC,
  parameter int WDT_PERIOD = 50000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  irq_flags,
  input  wire logic [7:0]  irq_enables,
  input  wire logic        primary_ready_in,
  input  wire logic        clock_lost,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             primary_osc_en,
  output logic             internal_osc_en,
  output logic             low_freq_osc_en,
  output logic [1:0]       periph_clk_sel,
  output logic             irq_vector_take,
  output logic             wdt_reset
);
  imwc_mode_t mode_r;
  logic [11:0] ctrl_r;
  logic        pri_flag_r;
  logic        sec_flag_r;
  logic        int_stable_r;
  logic        osc_was_on_r;
  logic        wake_irq_r;
  logic [1:0]  wake_sel_r;
  logic [7:0]  flags_prev_r;
  logic        aw_r;
  logic        w_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        boot_r;

  logic        idle_on_sleep_enable;
  logic [1:0]  clock_source_select;
  logic        secondary_osc_enable;
  logic [2:0]  internal_freq_select;
  logic        low_freq_source_select;
  logic        global_irq_enable;
  logic        wdt_en;
  logic        fscm_en;
  logic        twosp_en;
  logic        int_osc_req;
  logic        do_write;
  logic        sleep_cmd;
  logic        wdclr_cmd;
  logic        freq_sel_write;
  logic        irq_rise;
  logic        wdt_to;
  logic        wake_ev;
  logic        in_pm;
  logic        csd_done;
  logic        settle_done;
  logic        resume;
  logic [31:0] status_word;

  assign idle_on_sleep_enable   = ctrl_r[IMWC_CTL_IDLE_BIT];
  assign clock_source_select    = ctrl_r[IMWC_CTL_SCS_LSB +: 2];
  assign secondary_osc_enable   = ctrl_r[IMWC_CTL_T1EN_BIT];
  assign internal_freq_select   = ctrl_r[IMWC_CTL_FSEL_LSB +: 3];
  assign low_freq_source_select = ctrl_r[IMWC_CTL_LFSRC_BIT];
  assign global_irq_enable      = ctrl_r[IMWC_CTL_GIRQ_BIT];
  assign wdt_en                 = ctrl_r[IMWC_CTL_WDTEN_BIT];
  assign fscm_en                = ctrl_r[IMWC_CTL_FSCM_BIT];
  assign twosp_en               = ctrl_r[IMWC_CTL_TWOSP_BIT];
  assign int_osc_req = (internal_freq_select != 3'h0) || low_freq_source_select;

  // Write path: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r     <= 1'b0;
      w_r      <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r     <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r     <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_r <= 1'b0;
      end
    end
  end

  // Ready flags drop on their own handshake and come back once the response has gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_r && !s_axi_bvalid;
      s_axi_wready  <= !(s_axi_wvalid && s_axi_wready) && !w_r && !s_axi_bvalid;
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
    end
  end

  assign do_write      = aw_r && w_r && !s_axi_bvalid;
  assign sleep_cmd = do_write && awaddr_r == IMWC_CMD_OFS && wstrb_r[0]
                     && wdata_r[IMWC_CMD_SLEEP_BIT] && mode_r == IMWC_RUN;
  assign wdclr_cmd = do_write && awaddr_r == IMWC_CMD_OFS && wstrb_r[0]
                     && wdata_r[IMWC_CMD_WDCLR_BIT];
  assign freq_sel_write = do_write && awaddr_r == IMWC_CTRL_OFS && wstrb_r[0]
                          && clock_source_select[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == IMWC_CTRL_OFS || awaddr_r == IMWC_CMD_OFS) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; hardware never touches it on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= IMWC_CTRL_RST;
    end else if (do_write && awaddr_r == IMWC_CTRL_OFS) begin
      if (wstrb_r[0]) ctrl_r[7:0]  <= wdata_r[7:0];
      if (wstrb_r[1]) ctrl_r[11:8] <= wdata_r[11:8];
    end
  end

  // Read path
  assign status_word = {21'h0, primary_osc_en, low_freq_osc_en, internal_osc_en,
                        1'b0, mode_r, cpu_clk_en, int_stable_r, sec_flag_r, pri_flag_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case (s_axi_araddr)
        IMWC_CTRL_OFS:   s_axi_rdata <= {20'h0, ctrl_r};
        IMWC_STATUS_OFS: s_axi_rdata <= status_word;
        IMWC_CMD_OFS:    s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Wake sources
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_prev_r <= 8'h00;
    else          flags_prev_r <= irq_flags;
  end

  assign irq_rise = |(irq_flags & ~flags_prev_r & irq_enables);
  assign in_pm    = mode_r == IMWC_PRIMARY_IDLE_MODE || mode_r == IMWC_SECONDARY_IDLE_MODE
                    || mode_r == IMWC_INT_IDLE || mode_r == IMWC_SLEEP;
  assign wake_ev  = in_pm && (irq_rise || wdt_to);
  // Leave the wake state once the start delay is over and a clock can run the CPU
  assign resume   = mode_r == IMWC_WAKE && csd_done
                    && (wake_sel_r != 2'b00 || primary_ready_in || twosp_en || fscm_en);

  imwc_wdt u_wdt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (wdt_en),
    .clear   (sleep_cmd || wdclr_cmd || (clock_lost && fscm_en) || freq_sel_write),
    .period  (IMWC_WDT_W'(WDT_PERIOD)),
    .timeout (wdt_to)
  );

  imwc_delay u_csd (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (wake_ev),
    .clear   (1'b0),
    .len     (IMWC_CNT_W'(IMWC_TCSD_CYC)),
    .done    (csd_done)
  );

  imwc_delay u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (int_osc_req && !osc_was_on_r),
    .clear   (!int_osc_req),
    .len     (IMWC_CNT_W'(TIOBST_CYC)),
    .done    (settle_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) osc_was_on_r <= 1'b0;
    else          osc_was_on_r <= int_osc_req;
  end

  // Internal stable flag: no re-settle while already on
  always_ff @(posedge aclk) begin
    if (!aresetn || !int_osc_req) int_stable_r <= 1'b0;
    else if (settle_done)         int_stable_r <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_r <= 1'b0;
    end else begin
      boot_r <= 1'b1;
    end
  end

  // Mode sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r     <= IMWC_RSTHOLD;
      pri_flag_r <= 1'b0;
      sec_flag_r <= 1'b0;
      wake_irq_r <= 1'b0;
      wake_sel_r <= 2'b00;
    end else begin
      unique case (mode_r)
        IMWC_RSTHOLD: begin
          if (primary_ready_in) begin
            mode_r     <= IMWC_RUN;
            pri_flag_r <= 1'b1;
          end else if (boot_r && (twosp_en || fscm_en)) begin
            mode_r <= IMWC_RUN;
          end
        end
        IMWC_RUN: begin
          if (!pri_flag_r && primary_ready_in && !clock_source_select[1]
              && !sec_flag_r) begin
            pri_flag_r <= 1'b1;
          end
          if (sleep_cmd) begin
            if (!idle_on_sleep_enable) begin
              mode_r     <= IMWC_SLEEP;
              pri_flag_r <= 1'b0;
              sec_flag_r <= 1'b0;
            end else if (clock_source_select[1]) begin
              mode_r     <= IMWC_INT_IDLE;
              pri_flag_r <= 1'b0;
              sec_flag_r <= 1'b0;
            end else if (clock_source_select[0]) begin
              if (secondary_osc_enable) begin
                mode_r     <= IMWC_SECONDARY_IDLE_MODE;
                pri_flag_r <= 1'b0;
                sec_flag_r <= 1'b1;
              end
            end else begin
              mode_r <= IMWC_PRIMARY_IDLE_MODE;
            end
          end
        end
        IMWC_PRIMARY_IDLE_MODE, IMWC_SECONDARY_IDLE_MODE, IMWC_INT_IDLE, IMWC_SLEEP: begin
          if (wake_ev) begin
            mode_r     <= IMWC_WAKE;
            wake_irq_r <= irq_rise;
            wake_sel_r <= (mode_r == IMWC_SLEEP) ? 2'b00 : clock_source_select;
          end
        end
        IMWC_WAKE: begin
          if (resume) begin
            mode_r <= IMWC_RUN;
            if (wake_sel_r == 2'b00 && primary_ready_in) pri_flag_r <= 1'b1;
          end
        end
        default: mode_r <= IMWC_RSTHOLD;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en      <= 1'b0;
      periph_clk_en   <= 1'b0;
      primary_osc_en  <= 1'b1;
      internal_osc_en <= 1'b0;
      low_freq_osc_en <= 1'b1;
      periph_clk_sel  <= 2'b00;
      irq_vector_take <= 1'b0;
      wdt_reset       <= 1'b0;
    end else begin
      cpu_clk_en      <= mode_r == IMWC_RUN;
      periph_clk_en   <= mode_r != IMWC_SLEEP && mode_r != IMWC_RSTHOLD;
      primary_osc_en  <= mode_r == IMWC_PRIMARY_IDLE_MODE || mode_r == IMWC_RSTHOLD
                         || ((mode_r == IMWC_RUN || mode_r == IMWC_WAKE)
                             && !clock_source_select[1] && !sec_flag_r);
      internal_osc_en <= int_osc_req;
      low_freq_osc_en <= wdt_en || fscm_en || mode_r != IMWC_SLEEP;
      periph_clk_sel  <= clock_source_select[1] ? 2'b10 : {1'b0, clock_source_select[0]};
      irq_vector_take <= resume && wake_irq_r && global_irq_enable;
      wdt_reset       <= wdt_to && mode_r == IMWC_RUN;
    end
  end
endmodule

/* File: tb/imwc_monitor.sv */
// Checker for clock gating, wake timing and watchdog outputs
module imwc_monitor
  import imwc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] irq_flags,
  input  wire logic [7:0] irq_enables,
  input  wire logic       primary_ready_in,
  input  wire logic       cpu_clk_en,
  input  wire logic       periph_clk_en,
  input  wire logic       primary_osc_en,
  input  wire logic [1:0] periph_clk_sel,
  input  wire logic       irq_vector_take,
  input  wire logic       wdt_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flags_r;
  logic [4:0] low_r;
  logic       idle;
  logic       wake_ev;
  assign idle    = !cpu_clk_en && periph_clk_en;
  assign wake_ev = |(irq_flags & ~flags_r & irq_enables);
  // Previous flags and a saturating count of CPU-off cycles
  always_ff @(posedge aclk) begin
    flags_r <= irq_flags;
    if (!aresetn) low_r <= 5'h1F;
    else if (cpu_clk_en) low_r <= 5'h00;
    else if (low_r != 5'h1F) low_r <= low_r + 5'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_cpu_periph; cpu_clk_en |-> periph_clk_en; endproperty
  a_cpu_periph: assert property (p_cpu_periph)
    else $error("cpu clock runs without peripheral clock");
  property p_primary_idle_mode; idle && periph_clk_sel == 2'b00 |-> primary_osc_en; endproperty
  a_primary_idle_mode: assert property (p_primary_idle_mode)
    else $error("primary oscillator off in primary idle");
  property p_alt_idle; idle && periph_clk_sel != 2'b00 |-> !primary_osc_en; endproperty
  a_alt_idle: assert property (p_alt_idle)
    else $error("primary oscillator on in secondary or internal idle");
  property p_irq_wake; idle && wake_ev |-> ##[20:23] $rose(cpu_clk_en); endproperty
  a_irq_wake: assert property (p_irq_wake)
    else $error("enabled interrupt did not resume cpu after start delay");
  property p_csd; $rose(cpu_clk_en) && $past(periph_clk_en) |-> low_r >= 5'h14; endproperty
  a_csd: assert property (p_csd)
    else $error("cpu resumed before start delay");
  property p_vec; irq_vector_take |-> ##[0:1] cpu_clk_en ##1 !irq_vector_take; endproperty
  a_vec: assert property (p_vec)
    else $error("vector pulse not tied to cpu resume");
  property p_wdt_run; wdt_reset |-> $past(cpu_clk_en) ##1 !wdt_reset; endproperty
  a_wdt_run: assert property (p_wdt_run)
    else $error("watchdog reset outside run");
  property p_resume_sel;
    $rose(cpu_clk_en) && $past(periph_clk_en) |-> $stable(periph_clk_sel);
  endproperty
  a_resume_sel: assert property (p_resume_sel)
    else $error("clock source changed on resume");
  property p_ready; $rose(cpu_clk_en) && periph_clk_sel == 2'b00 |-> primary_ready_in; endproperty
  a_ready: assert property (p_ready)
    else $error("cpu started on primary before it was ready");
  c_wake: cover property (idle && wake_ev);
  c_vec: cover property (irq_vector_take);
  c_wdt: cover property (wdt_reset);
endmodule

bind imwc_top imwc_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .irq_flags(irq_flags),
  .irq_enables(irq_enables), .primary_ready_in(primary_ready_in), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .primary_osc_en(primary_osc_en),
  .periph_clk_sel(periph_clk_sel), .irq_vector_take(irq_vector_take), .wdt_reset(wdt_reset));

/* File: tb/imwc_partner.sv */
// Clock source model: primary oscillator start-up and clock loss
module imwc_partner #(
  parameter int START_CYC = 8
) (
  input  wire logic aclk,
  input  wire logic primary_osc_en,
  input  wire logic slow,
  input  wire logic lose,
  output logic      primary_ready_in,
  output logic      clock_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Ready only once the oscillator has run its start-up time
  always_ff @(posedge aclk) begin
    if (!primary_osc_en) begin
      cnt <= 0;
      primary_ready_in <= 1'b0;
    end else if (cnt < (slow ? 4 * START_CYC : START_CYC)) cnt <= cnt + 1;
    else primary_ready_in <= 1'b1;
  end
  assign clock_lost = lose && primary_osc_en;
endmodule

/* File: tb/imwc_top_bench.sv */
// Self-checking bench for the idle mode and wake controller
module imwc_top_bench
  import imwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [2:0]  mode;
    logic [1:0]  sel;
    logic        prim;
    logic [1:0]  st;
    logic        vec;
  } imwc_row_t;
  // Control value, then expected mode, clock select, primary on, status flags, vector
  localparam imwc_row_t ROWS [6] = '{'{12'h001, 3'h1, 2'h0, 1'b1, 2'h1, 1'b0},
    '{12'h101, 3'h1, 2'h0, 1'b1, 2'h1, 1'b1}, '{12'h003, 3'h0, 2'h1, 1'b1, 2'h1, 1'b0},
    '{12'h00B, 3'h2, 2'h1, 1'b0, 2'h2, 1'b0}, '{12'h01F, 3'h3, 2'h2, 1'b0, 2'h0, 1'b0},
    '{12'h00D, 3'h3, 2'h2, 1'b0, 2'h0, 1'b0}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow;
  logic primary_ready_in, clock_lost, cpu_clk_en, periph_clk_en, primary_osc_en;
  logic internal_osc_en, low_freq_osc_en, irq_vector_take, wdt_reset;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_flags, irq_enables;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, periph_clk_sel, r;
  int failures, compares, cyc, vec_cnt, wdt_cnt, n, v0;
  imwc_top #(.TIOBST_CYC(50), .WDT_PERIOD(100)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_flags(irq_flags),
    .irq_enables(irq_enables), .primary_ready_in(primary_ready_in), .clock_lost(clock_lost),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .primary_osc_en(primary_osc_en),
    .internal_osc_en(internal_osc_en), .low_freq_osc_en(low_freq_osc_en),
    .periph_clk_sel(periph_clk_sel), .irq_vector_take(irq_vector_take), .wdt_reset(wdt_reset));
  imwc_partner i_osc (.aclk(aclk), .primary_osc_en(primary_osc_en), .slow(slow), .lose(1'b0),
    .primary_ready_in(primary_ready_in), .clock_lost(clock_lost));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (irq_vector_take === 1'b1) vec_cnt <= vec_cnt + 1;
    if (wdt_reset === 1'b1) wdt_cnt <= wdt_cnt + 1;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    forever begin
      @(negedge aclk);
      if (!s_axi_awvalid && !s_axi_wvalid && !s_axi_arvalid) break;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) @(negedge aclk);
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_cpu();
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 3000);
  endtask
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_flags, slow} = '0;
    {failures, compares, cyc, vec_cnt, wdt_cnt} = '0;
    s_axi_wstrb = 4'hF;
    irq_enables = 8'h01;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_cpu();
    // Software order: idle enable and select first, then the sleep command
    foreach (ROWS[i]) begin
      bus(1'b1, IMWC_CTRL_OFS, {20'h00000, ROWS[i].ctrl});
      bus(1'b1, IMWC_CMD_OFS, 32'h00000001);
      bus(1'b0, IMWC_STATUS_OFS, 32'h00000000);
      chk(q[6:4], ROWS[i].mode);
      chk(q[1:0], ROWS[i].st);
      chk(periph_clk_sel, ROWS[i].sel);
      chk(primary_osc_en, ROWS[i].prim);
      chk(internal_osc_en, ROWS[i].ctrl[6:4] != 3'h0 || ROWS[i].ctrl[7]);
      chk(cpu_clk_en, ROWS[i].mode == 3'h0);
      if (ROWS[i].mode != 3'h0) begin
        v0 = vec_cnt;
        irq_flags <= 8'h01;
        wait_cpu();
        repeat (2) @(posedge aclk);
        chk(n >= 20, 1'b1);
        chk(vec_cnt - v0, ROWS[i].vec);
        irq_flags <= 8'h00;
      end
      bus(1'b0, IMWC_CTRL_OFS, 32'h00000000);
      chk(q[11:0], ROWS[i].ctrl);
      $display("row %0d done", i);
    end
    bus(1'b1, IMWC_CTRL_OFS, 32'h0000001D);
    bus(1'b0, IMWC_STATUS_OFS, 32'h00000000);
    chk(q[2], 1'b0);
    repeat (60) @(posedge aclk);
    bus(1'b1, IMWC_CMD_OFS, 32'h00000001);
    bus(1'b0, IMWC_STATUS_OFS, 32'h00000000);
    chk({q[6:4], q[2]}, 4'h7);
    @(posedge aclk);
    irq_enables <= 8'h00;
    irq_flags <= 8'h02;
    repeat (40) @(posedge aclk);
    chk(cpu_clk_en, 1'b0);
    irq_flags <= 8'h00;
    irq_enables <= 8'h02;
    @(posedge aclk);
    irq_flags <= 8'h02;
    wait_cpu();
    chk(cpu_clk_en, 1'b1);
    @(posedge aclk);
    irq_flags <= 8'h00;
    $display("masked interrupt test done");
    slow <= 1'b1;
    bus(1'b1, IMWC_CTRL_OFS, 32'h00000200);
    bus(1'b1, IMWC_CMD_OFS, 32'h00000001);
    bus(1'b0, IMWC_STATUS_OFS, 32'h00000000);
    chk(q[2:0], 3'h0);
    chk({periph_clk_en, primary_osc_en, low_freq_osc_en}, 3'h1);
    v0 = wdt_cnt;
    wait_cpu();
    chk({cpu_clk_en, n >= 80}, 2'h3);
    chk(wdt_cnt - v0, 0);
    repeat (4) begin
      repeat (50) @(negedge aclk);
      bus(1'b1, IMWC_CMD_OFS, 32'h00000002);
    end
    chk(wdt_cnt - v0, 0);
    n = 0;
    while (wdt_cnt == v0 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk(wdt_cnt != v0, 1'b1);
    $display("sleep and watchdog test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({cpu_clk_en, primary_osc_en, low_freq_osc_en}, 3'h3);
    @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, IMWC_CTRL_OFS, 32'h00000000);
    chk(q[11:0], IMWC_CTRL_RST);
    bus(1'b0, 8'h0C, 32'h00000000);
    chk({r, q}, {2'h2, 32'h00000000});
    wait_cpu();
    chk(cpu_clk_en, 1'b1);
    $display("reset test done");
    end_sim();
  end
endmodule
